//--- verilog/dual_clock_flagged_fifo.sv
// flagged fifo with pin-level write/read ports and a wishbone register slave
//
// Summary of operation
// R1 - read edge, read enable low, not empty: next word goes to output
// R2 - write edge, write enable low: input word stored at next location
// R3 - load low: read edge returns offset register instead of fifo data
// R4 - load low: data bits go to or come from offset registers
// R5 - shared output is half-full flag alone, write expansion out when cascaded
// R6 - empty flag low when no words, changed only on read edges
// R7 - full flag low when full, changed only on write edges
// R8 - almost-empty from empty offset; async if sync-select high, else read edges
// R9 - almost-full from full offset; async if sync-select high, else write edges
// R10 - system holds first-load low in width expansion and stand-alone
// R11 - stand-alone device retransmits when the shared pin is strobed
// R12 - cascade: write expand in from previous device, else held low
// R13 - cascade: read expand out feeds next device read expand in
// R14 - reset before any access; reset leaves fifo empty, empty flag low
// R15 - output enable high floats data outputs, low drives them
// R16 - array of 64 to 4k words of 18 bits, separate pointers
// R17 - after reset falls, data outputs low while output enable asserted
// R18 - no reads or writes while reset held low
// R19 - cascaded: only the read-enabled device drives its outputs
// R20 - writes ignored when full, reads ignored when empty
// R21 - empty fifo keeps last valid read word on outputs
// R22 - two 12-bit offsets, load writes alternate empty then full
// R23 - almost-empty when count at most empty offset; almost-full on free space
// R24 - retransmit pulse returns read pointer to first location
// R25 - each flag is evaluated only in its own domain, glitch free; code uses both pointers for half-full and async almost flags
// R26 - reset loads default offsets and clears both pointers
//
// The address map and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

`include "fifo_defines.svh"

module dual_clock_flagged_fifo
    import fifo_pkg::*;
#(
    parameter int DEPTH = `FIFO_DEPTH_DEFAULT,
    parameter logic [11:0] EMPTY_OFS_RST = `FIFO_OFS_RESET,
    parameter logic [11:0] FULL_OFS_RST = `FIFO_OFS_RESET
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic reset_n,
    input wire logic write_clk,
    input wire logic read_clk,
    input wire logic write_en_n,
    input wire logic read_en_n,
    input wire logic offset_load_n,
    input wire logic out_en_n,
    input wire logic replay_pulse,
    input wire logic write_expand_in,
    input wire logic read_expand_in,
    input wire logic flag_sync_select,
    input wire logic [17:0] data_in,
    output logic [17:0] data_out,
    output logic data_out_en,
    output logic empty_flag_n,
    output logic full_flag_n,
    output logic almost_empty_flag_n,
    output logic almost_full_flag_n,
    output logic half_full_flag_n,
    output logic read_expand_out
);

    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;
    localparam logic [12:0] DEPTH13 = 13'(DEPTH);
    localparam logic [12:0] HALF13 = 13'(DEPTH / 2);

    wb_req_s bus;
    word_t mem [DEPTH];
    logic [CW-1:0] wptr, rptr, next_wptr, next_rptr;
    logic [CW-1:0] count, cnt_rd_side, cnt_wr_side, cnt_both;
    ofs_t empty_ofs, full_ofs;
    logic load_wsel, load_rsel;
    logic cascade_mode, wr_token, rd_token, wexp_pulse;
    logic [31:0] ctrl;
    flags_s flags;

    assign bus = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                   adr: wb_adr_i, dat: wb_dat_i};

    // pin clocks are sampled levels; their rising edges act as strobes
    logic wclk_rise, rclk_rise, replay_rise;

    rise_detect u_wclk (.clk(clk), .rstn(rstn), .ce(ce), .level(write_clk), .rise(wclk_rise));
    rise_detect u_rclk (.clk(clk), .rstn(rstn), .ce(ce), .level(read_clk), .rise(rclk_rise));
    rise_detect u_replay (.clk(clk), .rstn(rstn), .ce(ce), .level(replay_pulse),
                          .rise(replay_rise));

    // shared pin: first-load in cascade, retransmit strobe stand-alone
    wire first_device_n = replay_pulse;
    wire fifo_clear = ~reset_n;
    assign cascade_mode = ctrl[`CTRL_CASCADE_BIT];

    // requests are masked while the device reset pin is low
    wire wr_req = wclk_rise & ~write_en_n & reset_n; // R18
    wire rd_req = rclk_rise & ~read_en_n & reset_n; // R18
    wire load_wr = wr_req & ~offset_load_n; // R4
    wire load_rd = rd_req & ~offset_load_n; // R3
    wire fifo_wr = wr_req & offset_load_n & full_flag_n & (~cascade_mode | wr_token); // R20
    wire fifo_rd = rd_req & offset_load_n & empty_flag_n & (~cascade_mode | rd_token); // R20
    wire replay_fire = replay_rise & ~cascade_mode & reset_n; // R11
    wire wr_wrap = fifo_wr & (&wptr[AW-1:0]);
    wire rd_wrap = fifo_rd & (&rptr[AW-1:0]);
    wire [AW-1:0] rd_idx = rptr[AW-1:0];

    assign next_wptr = fifo_wr ? wptr + CW'(1) : wptr; // R2
    assign next_rptr = replay_fire ? '0 : (fifo_rd ? rptr + CW'(1) : rptr); // R24
    assign count = wptr - rptr;
    assign cnt_rd_side = wptr - next_rptr; // R25
    assign cnt_wr_side = next_wptr - rptr; // R25
    assign cnt_both = next_wptr - next_rptr;

    wire [12:0] cr13 = 13'(cnt_rd_side);
    wire [12:0] cw13 = 13'(cnt_wr_side);
    wire [12:0] cb13 = 13'(cnt_both);
    wire next_empty_n = cr13 != 13'h0000; // R6
    wire next_full_n = cw13 != DEPTH13; // R7
    wire ae_sync_n = cr13 > {1'b0, empty_ofs}; // R23
    wire af_sync_n = (DEPTH13 - cw13) > {1'b0, full_ofs}; // R23
    wire ae_async_n = cb13 > {1'b0, empty_ofs};
    wire af_async_n = (DEPTH13 - cb13) > {1'b0, full_ofs};
    wire next_half_n = ~(cb13 > HALF13);
    wire [17:0] ofs_word = {6'h00, load_rsel ? full_ofs : empty_ofs};

    // storage array; no reset so it maps onto plain ram
    always_ff @(posedge clk)
    begin
        if (ce && fifo_wr)
            mem[wptr[AW-1:0]] <= data_in; // R16
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wptr <= '0;
            rptr <= '0;
        end
        else if (ce)
        begin
            wptr <= fifo_clear ? '0 : next_wptr; // R26
            rptr <= fifo_clear ? '0 : next_rptr; // R1
        end
    end

    // empty and full follow only their own strobe
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            empty_flag_n <= 1'b0;
            full_flag_n <= 1'b1;
        end
        else if (ce)
        begin
            if (fifo_clear)
                empty_flag_n <= 1'b0; // R14
            else if (rclk_rise)
                empty_flag_n <= next_empty_n; // R6
            if (fifo_clear)
                full_flag_n <= 1'b1;
            else if (wclk_rise)
                full_flag_n <= next_full_n; // R7
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            almost_empty_flag_n <= 1'b0;
            almost_full_flag_n <= 1'b1;
        end
        else if (ce)
        begin
            if (fifo_clear)
                almost_empty_flag_n <= 1'b0;
            else if (flag_sync_select)
                almost_empty_flag_n <= ae_async_n; // R8
            else if (rclk_rise)
                almost_empty_flag_n <= ae_sync_n; // R8
            if (fifo_clear)
                almost_full_flag_n <= 1'b1;
            else if (flag_sync_select)
                almost_full_flag_n <= af_async_n; // R9
            else if (wclk_rise)
                almost_full_flag_n <= af_sync_n; // R9
        end
    end

    // shared output: half-full level alone, one-cycle expansion pulse in cascade
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            half_full_flag_n <= 1'b1;
        else if (ce)
            half_full_flag_n <= cascade_mode ? ~wexp_pulse : (fifo_clear | next_half_n); // R5
    end

    // depth expansion tokens: a device hands over when its pointer wraps
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wr_token <= 1'b0;
            rd_token <= 1'b0;
            wexp_pulse <= 1'b0;
            read_expand_out <= 1'b0;
        end
        else if (ce)
        begin
            wexp_pulse <= cascade_mode & wr_wrap; // R5
            read_expand_out <= cascade_mode & rd_wrap; // R13
            if (fifo_clear)
            begin
                wr_token <= ~first_device_n;
                rd_token <= ~first_device_n;
            end
            else
            begin
                if (cascade_mode && write_expand_in)
                    wr_token <= 1'b1; // R12
                else if (wr_wrap)
                    wr_token <= 1'b0;
                if (cascade_mode && read_expand_in)
                    rd_token <= 1'b1;
                else if (rd_wrap)
                    rd_token <= 1'b0;
            end
        end
    end

    // output register; an empty fifo simply keeps the last word
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            data_out <= '0;
            data_out_en <= 1'b0;
        end
        else if (ce)
        begin
            data_out_en <= ~out_en_n & (~cascade_mode | rd_token); // R15 R19
            if (fifo_clear)
                data_out <= '0; // R17
            else if (load_rd)
                data_out <= ofs_word; // R3
            else if (fifo_rd)
                data_out <= mem[rptr[AW-1:0]]; // R1 R21
        end
    end

    // offsets: pin loads alternate and take priority over a bus write
    wire bus_req = bus.cyc & bus.stb & ~wb_ack_o;
    wire bus_wr = bus_req & bus.we;
    wire wr_eofs = bus_wr & (bus.adr == `REG_EMPTY_OFS);
    wire wr_fofs = bus_wr & (bus.adr == `REG_FULL_OFS);
    wire wr_ctrl = bus_wr & (bus.adr == `REG_CTRL);
    wire [11:0] bus_ofs_e = {bus.sel[1] ? bus.dat[11:8] : empty_ofs[11:8],
                             bus.sel[0] ? bus.dat[7:0] : empty_ofs[7:0]};
    wire [11:0] bus_ofs_f = {bus.sel[1] ? bus.dat[11:8] : full_ofs[11:8],
                             bus.sel[0] ? bus.dat[7:0] : full_ofs[7:0]};

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            empty_ofs <= EMPTY_OFS_RST;
            full_ofs <= FULL_OFS_RST;
            load_wsel <= 1'b0;
            load_rsel <= 1'b0;
        end
        else if (ce)
        begin
            if (fifo_clear)
            begin
                empty_ofs <= EMPTY_OFS_RST; // R26
                full_ofs <= FULL_OFS_RST;
                load_wsel <= 1'b0;
                load_rsel <= 1'b0;
            end
            else
            begin
                if (load_wr)
                    load_wsel <= ~load_wsel; // R22
                if (load_rd)
                    load_rsel <= ~load_rsel; // R22
                if (load_wr && !load_wsel)
                    empty_ofs <= data_in[11:0]; // R4 R22
                else if (wr_eofs)
                    empty_ofs <= bus_ofs_e;
                if (load_wr && load_wsel)
                    full_ofs <= data_in[11:0]; // R4 R22
                else if (wr_fofs)
                    full_ofs <= bus_ofs_f;
            end
        end
    end

    // register slave: one wait state, unmapped reads give zero
    assign flags = '{full_n: full_flag_n, almost_full_n: almost_full_flag_n,
                     half_full_n: next_half_n, almost_empty_n: almost_empty_flag_n,
                     empty_n: empty_flag_n};
    wire [31:0] status_word = {23'h000000, load_rsel, load_wsel, rd_token, wr_token, flags};
    wire [31:0] rd_mux = (bus.adr == `REG_CTRL) ? ctrl :
                         (bus.adr == `REG_STATUS) ? status_word :
                         (bus.adr == `REG_COUNT) ? 32'(count) :
                         (bus.adr == `REG_EMPTY_OFS) ? {20'h00000, empty_ofs} :
                         (bus.adr == `REG_FULL_OFS) ? {20'h00000, full_ofs} : 32'h0000_0000;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
            ctrl <= `CTRL_RESET;
        end
        else if (ce)
        begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? rd_mux : wb_dat_o;
            if (wr_ctrl && bus.sel[0])
                ctrl <= {31'h00000000, bus.dat[`CTRL_CASCADE_BIT]};
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    AST_WRITE_ADVANCES: assert property (ce && fifo_wr && !fifo_clear |=> wptr == $past(wptr) + CW'(1)) else $error("write did not advance pointer"); // R2
    AST_READ_LOADS_WORD: assert property (ce && fifo_rd && !fifo_clear && !replay_fire |=> rptr == $past(rptr) + CW'(1) && data_out == mem[$past(rd_idx)]) else $error("read word wrong"); // R1
    AST_FULL_IGNORES_WRITE: assert property (ce && wr_req && offset_load_n && !full_flag_n && !fifo_clear |=> $stable(wptr)) else $error("write accepted while full"); // R20
    AST_EMPTY_HOLDS_OUTPUT: assert property (ce && rd_req && offset_load_n && !empty_flag_n |=> $stable(data_out)) else $error("empty read changed output"); // R21
    AST_EMPTY_ONLY_READ_EDGE: assert property (ce && !rclk_rise && !fifo_clear |=> $stable(empty_flag_n)) else $error("empty flag moved without read edge"); // R6
    AST_FULL_ONLY_WRITE_EDGE: assert property (ce && !wclk_rise && !fifo_clear |=> $stable(full_flag_n)) else $error("full flag moved without write edge"); // R7
    AST_RESET_EMPTY: assert property (ce && fifo_clear |=> !empty_flag_n && count == '0 && data_out == '0) else $error("device reset did not empty fifo"); // R14
    AST_OE_FLOATS: assert property (ce && out_en_n |=> !data_out_en) else $error("outputs driven with enable high"); // R15
    AST_LOAD_ALTERNATES: assert property (ce && load_wr && !fifo_clear |=> load_wsel != $past(load_wsel)) else $error("offset sequence stuck"); // R22
    AST_REPLAY_REWINDS: assert property (ce && replay_fire && !fifo_clear |=> rptr == '0) else $error("retransmit did not rewind"); // R24
    AST_ACK_ONE_CYCLE: assert property (ce && bus_req ##1 ce |=> !wb_ack_o) else $error("ack held too long");

    COV_WRITE_THEN_READ: cover property (fifo_wr ##[1:20] fifo_rd);
    COV_FULL: cover property (!full_flag_n);
    COV_REPLAY: cover property (replay_fire);
    COV_OFFSET_PAIR: cover property (load_wr ##[1:20] load_wr);

endmodule // dual_clock_flagged_fifo

`default_nettype wire

//--- pkg/fifo_defines.svh
// constants for the flagged fifo: widths, offsets, reset values
`ifndef FIFO_DEFINES_SVH
`define FIFO_DEFINES_SVH

`define FIFO_DATA_W 18
`define FIFO_OFS_W 12
`define FIFO_DEPTH_DEFAULT 4096
`define FIFO_OFS_RESET 12'h07f

`define WB_ADR_W 8
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_COUNT 8'h08
`define REG_EMPTY_OFS 8'h0c
`define REG_FULL_OFS 8'h10

`define CTRL_CASCADE_BIT 0
`define CTRL_RESET 32'h0000_0000

`endif

//--- pkg/fifo_pkg.sv
// types shared by the flagged fifo design
package fifo_pkg;

    typedef logic [17:0] word_t;
    typedef logic [11:0] ofs_t;

    typedef struct packed {
        logic full_n;
        logic almost_full_n;
        logic half_full_n;
        logic almost_empty_n;
        logic empty_n;
    } flags_s;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } wb_req_s;

endpackage

//--- verilog/rise_detect.sv
// rising edge finder for a pin sampled on clk
`timescale 1ns/1ns
`default_nettype none

module rise_detect
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic level,
    output logic rise
);

    logic prev;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            prev <= 1'b0;
        else if (ce)
            prev <= level;
    end

    assign rise = level & ~prev;

endmodule // rise_detect

`default_nettype wire

//--- bench/pin_port_model.sv
// producer and consumer model that drives the fifo write and read pins
`timescale 1ns/1ns
`default_nettype none

module pin_port_model
(
    input wire logic clk,
    output logic write_clk,
    output logic write_en_n,
    output logic [17:0] data_in,
    output logic read_clk,
    output logic read_en_n
);
    // idle cycles before each transfer, so the far side can also be slow
    int gap = 0;

    initial
    begin
        write_clk = 1'h0;
        write_en_n = 1'h1;
        data_in = 18'h00000;
        read_clk = 1'h0;
        read_en_n = 1'h1;
    end

    // one write-clock rise per word; released data is inverted so stale words never match
    task automatic push(input logic [17:0] word);
        repeat (gap) @(posedge clk);
        @(posedge clk);
        write_clk <= 1'h1;
        write_en_n <= 1'h0;
        data_in <= word;
        @(posedge clk);
        write_clk <= 1'h0;
        write_en_n <= 1'h1;
        data_in <= ~word;
    endtask

    // pin clocks stand low between transfers, so each call makes exactly one rising edge
    task automatic pop();
        repeat (gap) @(posedge clk);
        @(posedge clk);
        read_clk <= 1'h1;
        read_en_n <= 1'h0;
        @(posedge clk);
        read_clk <= 1'h0;
        read_en_n <= 1'h1;
    endtask
endmodule // pin_port_model

`default_nettype wire

//--- bench/dual_clock_flagged_fifo_tb.sv
// self-checking bench for the flagged fifo pin ports and register slave
`timescale 1ns/1ns
`default_nettype none

`include "fifo_defines.svh"

module dual_clock_flagged_fifo_tb import fifo_pkg::*;;
    logic clk, write_clk, read_clk, write_en_n, read_en_n, data_out_en, wb_ack;
    logic rstn, reset_n, out_en_n, offset_load_n, ce, wexp_in, rexp_in;
    logic replay_pulse, flag_sync_select, wb_cyc, wb_stb, wb_we;
    logic [3:0] wb_sel, bsel;
    logic [7:0] wb_adr;
    logic [31:0] wb_dat_w, wb_dat_r, rd;
    word_t data_in, data_out;
    wire flags_s fl;
    int errors = 0;
    int num_checks = 0;

    dual_clock_flagged_fifo #(.DEPTH(64)) i_dut
    (
        .clk(clk), .rstn(rstn), .ce(ce), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_sel_i(wb_sel), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat_w),
        .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack), .reset_n(reset_n), .write_clk(write_clk),
        .read_clk(read_clk), .write_en_n(write_en_n), .read_en_n(read_en_n),
        .offset_load_n(offset_load_n), .out_en_n(out_en_n), .replay_pulse(replay_pulse),
        .write_expand_in(wexp_in), .read_expand_in(rexp_in),
        .flag_sync_select(flag_sync_select), .data_in(data_in), .data_out(data_out),
        .data_out_en(data_out_en), .empty_flag_n(fl.empty_n), .full_flag_n(fl.full_n),
        .almost_empty_flag_n(fl.almost_empty_n), .almost_full_flag_n(fl.almost_full_n),
        .half_full_flag_n(fl.half_full_n), .read_expand_out()
    );

    pin_port_model i_ports
    (
        .clk(clk), .write_clk(write_clk), .write_en_n(write_en_n), .data_in(data_in),
        .read_clk(read_clk), .read_en_n(read_en_n)
    );

    initial
    begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end

    initial
    begin
        #2000000;
        errors++;
        end_sim();
    end

    task automatic end_sim();
        if (errors == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // classic single cycle; read data is taken at the edge that samples ack high
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wdat);
        @(posedge clk);
        wb_cyc <= 1'h1;
        wb_stb <= 1'h1;
        wb_we <= we;
        wb_sel <= bsel;
        wb_adr <= adr;
        wb_dat_w <= wdat;
        // no local limit: only the watchdog ends a wait for ack
        do
            @(posedge clk);
        while (wb_ack !== 1'h1);
        rd = wb_dat_r;
        wb_cyc <= 1'h0;
        wb_stb <= 1'h0;
        wb_we <= 1'h0;
    endtask

    task automatic rdq(input word_t exp);
        i_ports.pop();
        @(negedge clk);
        check("data_out", data_out, exp);
    endtask

    task automatic t_reset();
        @(negedge clk);
        check("flags", fl, 5'h1c);
        check("data_out", data_out, 18'h00000);
        check("oe", data_out_en, 1'h1);
        wb(1'h0, `REG_EMPTY_OFS, 32'h0);
        check("empty_ofs", rd, 32'h07f);
        wb(1'h0, `REG_FULL_OFS, 32'h0);
        check("full_ofs", rd, 32'h07f);
        wb(1'h0, 8'h14, 32'h0);
        check("unmapped", rd, 32'h0);
    endtask

    task automatic t_offsets();
        @(posedge clk);
        offset_load_n <= 1'h0;
        i_ports.push(18'h3f009);
        i_ports.push(18'h3f003);
        @(posedge clk);
        offset_load_n <= 1'h1;
        @(posedge clk);
        offset_load_n <= 1'h0;
        i_ports.push(18'h3f004);
        wb(1'h0, `REG_EMPTY_OFS, 32'h0);
        check("empty_ofs", rd, 32'h004);
        wb(1'h0, `REG_FULL_OFS, 32'h0);
        check("full_ofs", rd, 32'h003);
        wb(1'h0, `REG_COUNT, 32'h0);
        check("count", rd, 32'h0);
        rdq(18'h00004);
        rdq(18'h00003);
        @(posedge clk);
        offset_load_n <= 1'h1;
        wb(1'h1, `REG_FULL_OFS, 32'hffff_f155);
        wb(1'h0, `REG_FULL_OFS, 32'h0);
        check("full_ofs", rd, 32'h155);
        bsel = 4'h1;
        wb(1'h1, `REG_FULL_OFS, 32'hffff_f003);
        wb(1'h0, `REG_FULL_OFS, 32'h0);
        check("full_ofs", rd, 32'h103);
        bsel = 4'hf;
        wb(1'h1, `REG_FULL_OFS, 32'hffff_f003);
        wb(1'h0, `REG_FULL_OFS, 32'h0);
        check("full_ofs", rd, 32'h003);
    endtask

    task automatic t_almost_empty();
        for (int i = 1; i <= 6; i++)
            i_ports.push(18'h00010 + 18'(i));
        repeat (4) @(negedge clk);
        check("flags", fl, 5'h1c);
        @(posedge clk);
        flag_sync_select <= 1'h1;
        repeat (4) @(negedge clk);
        check("flags", fl, 5'h1e);
        rdq(18'h00003);
        check("flags", fl, 5'h1f);
        rdq(18'h00011);
        rdq(18'h00012);
        check("flags", fl, 5'h1d);
        for (int i = 3; i <= 6; i++)
            rdq(18'h00010 + 18'(i));
        check("flags", fl, 5'h1c);
        rdq(18'h00016);
        @(posedge clk);
        flag_sync_select <= 1'h0;
    endtask

    task automatic t_fill();
        for (int i = 1; i <= 64; i++)
        begin
            i_ports.push(18'h00100 + 18'(i));
            @(negedge clk);
            if (i == 32 || i == 33)
                check("half_full", fl.half_full_n, i == 32);
            if (i == 60 || i == 61)
                check("almost_full", fl.almost_full_n, i == 60);
            if (i >= 63)
                check("full", fl.full_n, i == 63);
        end
        i_ports.push(18'h3ffff);
        wb(1'h0, `REG_COUNT, 32'h0);
        check("count", rd, 32'h040);
        i_ports.gap = 2;
        rdq(18'h00016);
        for (int i = 1; i <= 64; i++)
            rdq(18'h00100 + 18'(i));
        rdq(18'h00140);
        i_ports.gap = 0;
    endtask

    task automatic t_replay();
        @(posedge clk);
        out_en_n <= 1'h1;
        repeat (2) @(negedge clk);
        check("oe", data_out_en, 1'h0);
        @(posedge clk);
        out_en_n <= 1'h0;
        reset_n <= 1'h0;
        @(posedge clk);
        reset_n <= 1'h1;
        @(negedge clk);
        check("data_out", data_out, 18'h00000);
        check("empty", fl.empty_n, 1'h0);
        check("oe", data_out_en, 1'h1);
        wb(1'h0, `REG_EMPTY_OFS, 32'h0);
        check("empty_ofs", rd, 32'h07f);
        i_ports.push(18'h2aaaa);
        i_ports.push(18'h15555);
        i_ports.push(18'h3c3c3);
        rdq(18'h00000);
        rdq(18'h2aaaa);
        rdq(18'h15555);
        @(posedge clk);
        replay_pulse <= 1'h1;
        @(posedge clk);
        replay_pulse <= 1'h0;
        repeat (2) @(posedge clk);
        rdq(18'h2aaaa);
        rdq(18'h15555);
        rdq(18'h3c3c3);
        rdq(18'h3c3c3);
    endtask

    // clock enable freeze, then a cascaded non-first device waiting for its tokens
    task automatic t_cascade();
        @(posedge clk);
        ce <= 1'h0;
        i_ports.push(18'h00abc);
        @(posedge clk);
        ce <= 1'h1;
        wb(1'h0, `REG_COUNT, 32'h0);
        check("count", rd, 32'h0);
        wb(1'h1, `REG_CTRL, 32'h1);
        @(posedge clk);
        replay_pulse <= 1'h1;
        reset_n <= 1'h0;
        @(posedge clk);
        reset_n <= 1'h1;
        i_ports.push(18'h01234);
        @(negedge clk);
        check("oe", data_out_en, 1'h0);
        wb(1'h0, `REG_COUNT, 32'h0);
        check("count", rd, 32'h0);
        @(posedge clk);
        wexp_in <= 1'h1;
        rexp_in <= 1'h1;
        @(posedge clk);
        wexp_in <= 1'h0;
        rexp_in <= 1'h0;
        i_ports.push(18'h01234);
        rdq(18'h00000);
        rdq(18'h01234);
        check("oe", data_out_en, 1'h1);
        @(posedge clk);
        replay_pulse <= 1'h0;
    endtask

    initial
    begin
        rstn <= 1'h0;
        reset_n <= 1'h1;
        ce <= 1'h1;
        out_en_n <= 1'h0;
        offset_load_n <= 1'h1;
        replay_pulse <= 1'h0;
        flag_sync_select <= 1'h0;
        wexp_in <= 1'h0;
        rexp_in <= 1'h0;
        wb_cyc <= 1'h0;
        wb_stb <= 1'h0;
        wb_we <= 1'h0;
        wb_sel <= 4'h0;
        wb_adr <= 8'h00;
        wb_dat_w <= 32'h0;
        bsel = 4'hf;
        repeat (20) @(posedge clk);
        rstn <= 1'h1;
        repeat (2) @(posedge clk);
        t_reset();
        t_offsets();
        t_almost_empty();
        t_fill();
        t_replay();
        t_cascade();
        end_sim();
    end
endmodule // dual_clock_flagged_fifo_tb

`default_nettype wire
